/* File: design/cde_engine.sv */
// Descriptor-chained crypto DMA controller: fetches descriptors, moves
// data through external cipher and hash cores, writes results back.
// Assumes a single-beat memory master port and cipher/hash cores on the
// same clock; all inputs are synchronous to ref_clk_in.
`timescale 1ns/1ps
`include "cde_defines.svh"

// Contract
// RULE_01: Work is fetched by an internal DMA reading descriptors that hold the association and the buffer pointers.
// RULE_02: Every descriptor brings its own association, so keys and algorithms may change per descriptor.
// RULE_03: A control machine dispatches words to the cipher and hash cores by protocol and marks packet ends.
// RULE_04: Cipher and hash may run on the same data either in series or in parallel.
// RULE_05: AES takes 128, 192 or 256 bit keys.
// RULE_06: AES runs in CBC, ECB, CTR, CFB and OFB modes.
// RULE_07: DES and TDES run in CBC, ECB, CFB and OFB modes, without counter mode.
// RULE_08: Authentication offers SHA-1, SHA-256, MD5 and AES-GCM.
// RULE_09: A keyed-hash variant is allowed for every authentication algorithm.
// RULE_10: All logic runs from the one crypto bus clock.
// RULE_11: Software supplies a word-aligned 32-bit source pointer per descriptor.
// RULE_12: Software supplies a word-aligned 32-bit destination pointer per descriptor.
// RULE_13: After a descriptor the DMA follows its next pointer, segment or new packet alike.
// RULE_14: Result words go to the memory named by the write-back pointer.
// RULE_15: The length word is the message byte count, or the cipher byte count for GCM.
// RULE_16: The offset word is where ciphering starts, or the AAD byte count for GCM.
// RULE_17: Descriptor completion and bus errors show as status flags software can read.
module cde_engine (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Software control and status.
  input wire logic start_in,
  input wire logic [31:0] first_desc_in,
  input wire logic clear_in,
  output logic busy_out,
  output cde_pkg::cde_status_t stat_out,
  // Memory master.
  output cde_pkg::cde_mem_req_t mem_out,
  input wire logic mem_ack_in,
  input wire logic mem_err_in,
  input wire logic [31:0] mem_rdata_in,
  // Association handed to the cores.
  output cde_pkg::cde_sa_t sa_out,
  output logic sa_load_out,
  // Cipher core.
  output logic cph_valid_out,
  output cde_pkg::cde_word_t cph_word_out,
  input wire logic cph_ready_in,
  input wire logic cph_rvalid_in,
  input wire logic [31:0] cph_rdata_in,
  // Hash core.
  output logic hsh_valid_out,
  output cde_pkg::cde_word_t hsh_word_out,
  input wire logic hsh_ready_in,
  output logic dig_ready_out,
  input wire logic dig_valid_in,
  input wire logic [31:0] dig_data_in
);

  // ===================================================================
  // State and datapath registers.
  cde_pkg::cde_state_t state_q, state_d;
  cde_pkg::cde_sa_t sa_q, sa_d;
  cde_pkg::cde_status_t stat_q, stat_d;
  logic [31:0] ptr_q, ptr_d, src_q, src_d, dst_q, dst_d, nxt_q, nxt_d;
  logic [31:0] wb_q, wb_d, len_q, len_d, off_q, off_d;
  logic [31:0] nwords_q, nwords_d, widx_q, widx_d;
  logic [31:0] data_q, data_d, res_q, res_d, addr_q, addr_d, wdata_q, wdata_d;
  logic [2:0] idx_q, idx_d;
  logic [3:0] dcnt_q, dcnt_d;
  logic c_sent_q, c_sent_d, c_done_q, c_done_d, h_sent_q, h_sent_d;

  // ===================================================================
  // Decoded association and per-word steering.
  logic auth_on, sa_ok, use_c, use_h, last_word, word_ready, mem_busy;
  logic [31:0] byte_pos, tot_bytes, out_word;
  logic [3:0] dig_words;

  assign auth_on = sa_q.gcm || (sa_q.hash != cde_pkg::CDE_HASH_NONE);
  assign byte_pos = {widx_q[29:0], 2'h0};
  // RULE_16 cipher start offset
  assign use_c = (sa_q.cipher != cde_pkg::CDE_CIPH_NONE) && (byte_pos >= off_q);
  assign use_h = auth_on;
  assign last_word = sa_q.last_seg && (widx_q + 32'h1 == nwords_q);
  assign word_ready = (!use_c || c_done_q) && (!use_h || h_sent_q);
  assign out_word = use_c ? res_q : data_q;
  assign mem_busy = mem_out.req;
  // RULE_15 length per algorithm
  assign tot_bytes = sa_q.gcm ? len_q + off_q : len_q;

  // Association check; GCM needs AES and a keyed variant is legal with any hash.
  always_comb begin
    sa_ok = 1'b1;
    // RULE_05 key size check
    if (sa_q.cipher == cde_pkg::CDE_CIPH_AES && sa_q.key > cde_pkg::CDE_KEY_256) begin
      sa_ok = 1'b0;
    end
    // RULE_06 AES mode set
    if (sa_q.mode > cde_pkg::CDE_MODE_OFB) begin
      sa_ok = 1'b0;
    end
    // RULE_07 no DES counter
    if ((sa_q.cipher == cde_pkg::CDE_CIPH_DES || sa_q.cipher == cde_pkg::CDE_CIPH_TDES) &&
        sa_q.mode == cde_pkg::CDE_MODE_CTR) begin
      sa_ok = 1'b0;
    end
    // RULE_08 GCM pairs with AES
    if (sa_q.gcm && (sa_q.cipher != cde_pkg::CDE_CIPH_AES || sa_q.hash != cde_pkg::CDE_HASH_NONE)) begin
      sa_ok = 1'b0;
    end
    if (sa_q.cipher > cde_pkg::CDE_CIPH_TDES) begin
      sa_ok = 1'b0;
    end
    // RULE_09 keyed hash allowed
    if (sa_q.hmac && !auth_on) begin
      sa_ok = 1'b0;
    end
  end

  // Result length in words for the chosen authentication algorithm.
  always_comb begin
    case (sa_q.hash)
      cde_pkg::CDE_HASH_MD5: dig_words = `CDE_DIG_MD5;
      cde_pkg::CDE_HASH_SHA1: dig_words = `CDE_DIG_SHA1;
      cde_pkg::CDE_HASH_SHA256: dig_words = `CDE_DIG_SHA256;
      default: dig_words = sa_q.gcm ? `CDE_DIG_GCM : `CDE_DIG_NONE;
    endcase
  end

  // ===================================================================
  // Handshake outputs decode the state; data outputs are registers.
  assign busy_out = (state_q != cde_pkg::CDE_S_IDLE);
  assign stat_out = stat_q;
  assign sa_out = sa_q;
  assign sa_load_out = (state_q == cde_pkg::CDE_S_CHECK) && sa_ok;
  assign mem_out.req = (state_q == cde_pkg::CDE_S_FETCH) || (state_q == cde_pkg::CDE_S_READ) ||
                       (state_q == cde_pkg::CDE_S_WRITE) || (state_q == cde_pkg::CDE_S_WBACK);
  assign mem_out.we = (state_q == cde_pkg::CDE_S_WRITE) || (state_q == cde_pkg::CDE_S_WBACK);
  assign mem_out.addr = addr_q;
  assign mem_out.wdata = wdata_q;
  assign cph_valid_out = (state_q == cde_pkg::CDE_S_PROC) && use_c && !c_sent_q;
  assign cph_word_out = '{last: last_word, data: data_q};
  // RULE_04 series or parallel
  assign hsh_valid_out = (state_q == cde_pkg::CDE_S_PROC) && use_h && !h_sent_q &&
                         (sa_q.parallel || !use_c || c_done_q);
  // RULE_03 packet boundary mark
  assign hsh_word_out = '{last: last_word, data: (use_c && !sa_q.parallel) ? res_q : data_q};
  assign dig_ready_out = (state_q == cde_pkg::CDE_S_DIGEST);

  // ===================================================================
  // Next-state logic for the descriptor walk and data movement.
  always_comb begin
    state_d = state_q;
    sa_d = sa_q;
    ptr_d = ptr_q;
    src_d = src_q;
    dst_d = dst_q;
    nxt_d = nxt_q;
    wb_d = wb_q;
    len_d = len_q;
    off_d = off_q;
    nwords_d = nwords_q;
    widx_d = widx_q;
    data_d = data_q;
    res_d = res_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    idx_d = idx_q;
    dcnt_d = dcnt_q;
    c_sent_d = c_sent_q;
    c_done_d = c_done_q;
    h_sent_d = h_sent_q;
    stat_d = stat_q;
    // Software clears first so that a same-cycle event still lands.
    if (clear_in) begin
      stat_d = '0;
    end
    if (mem_busy && mem_err_in) begin
      // RULE_17 bus error flag
      stat_d.bus_err = 1'b1;
      state_d = cde_pkg::CDE_S_ERR;
    end else begin
      case (state_q)
        cde_pkg::CDE_S_IDLE: begin
          if (start_in) begin
            ptr_d = first_desc_in;
            addr_d = first_desc_in;
            idx_d = `CDE_DW_SA;
            state_d = cde_pkg::CDE_S_FETCH;
          end
        end
        cde_pkg::CDE_S_FETCH: begin
          if (mem_ack_in) begin
            // RULE_01 descriptor gather
            case (idx_q)
              // RULE_02 association per descriptor
              `CDE_DW_SA: sa_d = cde_pkg::cde_sa_t'(mem_rdata_in);
              `CDE_DW_SRC: src_d = mem_rdata_in;
              `CDE_DW_DST: dst_d = mem_rdata_in;
              `CDE_DW_NXT: nxt_d = mem_rdata_in;
              `CDE_DW_WB: wb_d = mem_rdata_in;
              `CDE_DW_LEN: len_d = mem_rdata_in;
              default: off_d = mem_rdata_in;
            endcase
            idx_d = idx_q + 3'h1;
            addr_d = ptr_q + {27'h0, idx_q + 3'h1, 2'h0};
            if (idx_q == `CDE_DW_LAST) begin
              state_d = cde_pkg::CDE_S_CHECK;
            end
          end
        end
        cde_pkg::CDE_S_CHECK: begin
          widx_d = `CDE_WORD_RST;
          dcnt_d = 4'h0;
          nwords_d = {2'h0, tot_bytes[31:2]} + {31'h0, |tot_bytes[1:0]};
          // RULE_11 aligned source assumed
          addr_d = src_q;
          if (!sa_ok) begin
            stat_d.cfg_err = 1'b1;
            state_d = cde_pkg::CDE_S_ERR;
          end else if (tot_bytes == `CDE_WORD_RST) begin
            state_d = cde_pkg::CDE_S_NEXT;
          end else begin
            state_d = cde_pkg::CDE_S_READ;
          end
        end
        cde_pkg::CDE_S_READ: begin
          if (mem_ack_in) begin
            data_d = mem_rdata_in;
            c_sent_d = 1'b0;
            c_done_d = 1'b0;
            h_sent_d = 1'b0;
            state_d = cde_pkg::CDE_S_PROC;
          end
        end
        cde_pkg::CDE_S_PROC: begin
          // RULE_03 dispatch to cores
          if (cph_valid_out && cph_ready_in) begin
            c_sent_d = 1'b1;
          end
          if (c_sent_q && !c_done_q && cph_rvalid_in) begin
            res_d = cph_rdata_in;
            c_done_d = 1'b1;
          end
          if (hsh_valid_out && hsh_ready_in) begin
            h_sent_d = 1'b1;
          end
          if (word_ready) begin
            // RULE_12 aligned destination assumed
            addr_d = dst_q + byte_pos;
            wdata_d = out_word;
            state_d = cde_pkg::CDE_S_WRITE;
          end
        end
        cde_pkg::CDE_S_WRITE: begin
          if (mem_ack_in) begin
            widx_d = widx_q + 32'h1;
            addr_d = src_q + byte_pos + 32'h4;
            if (widx_q + 32'h1 != nwords_q) begin
              state_d = cde_pkg::CDE_S_READ;
            end else if (sa_q.last_seg && auth_on) begin
              state_d = cde_pkg::CDE_S_DIGEST;
            end else begin
              state_d = cde_pkg::CDE_S_NEXT;
            end
          end
        end
        cde_pkg::CDE_S_DIGEST: begin
          if (dig_valid_in) begin
            // RULE_14 result to write-back
            addr_d = wb_q + {26'h0, dcnt_q, 2'h0};
            wdata_d = dig_data_in;
            state_d = cde_pkg::CDE_S_WBACK;
          end
        end
        cde_pkg::CDE_S_WBACK: begin
          if (mem_ack_in) begin
            dcnt_d = dcnt_q + 4'h1;
            state_d = (dcnt_q + 4'h1 == dig_words) ? cde_pkg::CDE_S_NEXT : cde_pkg::CDE_S_DIGEST;
          end
        end
        cde_pkg::CDE_S_NEXT: begin
          // RULE_17 completion flags
          stat_d.desc_done = 1'b1;
          if (sa_q.last_seg) begin
            stat_d.pkt_done = 1'b1;
          end
          // RULE_13 follow next pointer
          if (nxt_q == `CDE_NULL_PTR) begin
            state_d = cde_pkg::CDE_S_IDLE;
          end else begin
            ptr_d = nxt_q;
            addr_d = nxt_q;
            idx_d = `CDE_DW_SA;
            state_d = cde_pkg::CDE_S_FETCH;
          end
        end
        cde_pkg::CDE_S_ERR: begin
          state_d = cde_pkg::CDE_S_IDLE;
        end
        default: begin
          state_d = cde_pkg::CDE_S_IDLE;
        end
      endcase
    end
  end

  // ===================================================================
  // Register stage; the whole block lives on the one bus clock.
  // RULE_10 single clock
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= cde_pkg::CDE_S_IDLE;
      sa_q <= '0;
      stat_q <= '0;
      ptr_q <= `CDE_WORD_RST;
      src_q <= `CDE_WORD_RST;
      dst_q <= `CDE_WORD_RST;
      nxt_q <= `CDE_WORD_RST;
      wb_q <= `CDE_WORD_RST;
      len_q <= `CDE_WORD_RST;
      off_q <= `CDE_WORD_RST;
      nwords_q <= `CDE_WORD_RST;
      widx_q <= `CDE_WORD_RST;
      data_q <= `CDE_WORD_RST;
      res_q <= `CDE_WORD_RST;
      addr_q <= `CDE_WORD_RST;
      wdata_q <= `CDE_WORD_RST;
      idx_q <= `CDE_DW_SA;
      dcnt_q <= 4'h0;
      c_sent_q <= 1'b0;
      c_done_q <= 1'b0;
      h_sent_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sa_q <= sa_d;
      stat_q <= stat_d;
      ptr_q <= ptr_d;
      src_q <= src_d;
      dst_q <= dst_d;
      nxt_q <= nxt_d;
      wb_q <= wb_d;
      len_q <= len_d;
      off_q <= off_d;
      nwords_q <= nwords_d;
      widx_q <= widx_d;
      data_q <= data_d;
      res_q <= res_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      idx_q <= idx_d;
      dcnt_q <= dcnt_d;
      c_sent_q <= c_sent_d;
      c_done_q <= c_done_d;
      h_sent_q <= h_sent_d;
    end
  end

  // ===================================================================
  // Checks on the controller's own behaviour.
  AST_FETCH_ADDR: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_01
    state_q == cde_pkg::CDE_S_FETCH |-> addr_q == ptr_q + {27'h0, idx_q, 2'h0})
    else $error("Descriptor fetch address is wrong.");
  AST_SA_LOAD: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_02
    state_q == cde_pkg::CDE_S_FETCH && idx_q == `CDE_DW_SA && mem_ack_in && !mem_err_in
    |=> sa_q == $past(mem_rdata_in))
    else $error("Association not taken from descriptor.");
  AST_SERIES: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_04
    hsh_valid_out && use_c && !sa_q.parallel |-> c_done_q && hsh_word_out.data == res_q)
    else $error("Serial hash ran before the cipher result.");
  AST_KEY: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_05
    sa_load_out && sa_q.cipher == cde_pkg::CDE_CIPH_AES |-> sa_q.key != 2'h3)
    else $error("Illegal AES key size accepted.");
  AST_NO_DES_CTR: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_07
    sa_load_out && sa_q.cipher inside {cde_pkg::CDE_CIPH_DES, cde_pkg::CDE_CIPH_TDES}
    |-> sa_q.mode != cde_pkg::CDE_MODE_CTR)
    else $error("DES counter mode accepted.");
  AST_NEXT_PTR: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_13
    state_q == cde_pkg::CDE_S_NEXT && nxt_q != `CDE_NULL_PTR
    |=> state_q == cde_pkg::CDE_S_FETCH && ptr_q == $past(nxt_q) && idx_q == `CDE_DW_SA)
    else $error("Next descriptor pointer not followed.");
  AST_WB_ADDR: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_14
    state_q == cde_pkg::CDE_S_WBACK |-> mem_out.we && addr_q == wb_q + {26'h0, dcnt_q, 2'h0})
    else $error("Result written to the wrong address.");
  AST_GCM_START: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_16
    cph_valid_out |-> byte_pos >= off_q)
    else $error("Cipher started before the offset.");
  AST_DONE_FLAG: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_17
    state_q == cde_pkg::CDE_S_NEXT |=> stat_q.desc_done)
    else $error("Descriptor completion flag missing.");
  AST_ERR_FLAG: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_17
    mem_out.req && mem_err_in |=> stat_q.bus_err ##1 state_q == cde_pkg::CDE_S_IDLE)
    else $error("Bus error not flagged or not stopped.");

endmodule // cde_engine

/* File: design/cde_defines.svh */
// Constants for the descriptor-driven crypto DMA engine.
// Assumes inclusion by bare name from design files only.
`ifndef CDE_DEFINES_SVH
`define CDE_DEFINES_SVH

// =====================================================================
// Descriptor word indices, one 32-bit word each, consecutive in memory.
`define CDE_DW_SA 3'h0
`define CDE_DW_SRC 3'h1
`define CDE_DW_DST 3'h2
`define CDE_DW_NXT 3'h3
`define CDE_DW_WB 3'h4
`define CDE_DW_LEN 3'h5
`define CDE_DW_OFF 3'h6
`define CDE_DW_LAST 3'h6

// =====================================================================
// Reset values and the end-of-chain marker.
`define CDE_WORD_RST 32'h0000_0000
`define CDE_NULL_PTR 32'h0000_0000

// =====================================================================
// Result words written back per authentication algorithm.
`define CDE_DIG_MD5 4'h4
`define CDE_DIG_SHA1 4'h5
`define CDE_DIG_SHA256 4'h8
`define CDE_DIG_GCM 4'h4
`define CDE_DIG_NONE 4'h0

`endif

/* File: design/cde_pkg.sv */
// Types shared by the crypto DMA engine and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package cde_pkg;

  // ===================================================================
  // Security association fields carried in descriptor word 0.
  typedef enum logic [2:0] {CDE_CIPH_NONE = 3'h0, CDE_CIPH_AES = 3'h1, CDE_CIPH_DES = 3'h2,
                            CDE_CIPH_TDES = 3'h3} cde_cipher_t;
  typedef enum logic [2:0] {CDE_MODE_ECB = 3'h0, CDE_MODE_CBC = 3'h1, CDE_MODE_CTR = 3'h2,
                            CDE_MODE_CFB = 3'h3, CDE_MODE_OFB = 3'h4} cde_mode_t;
  typedef enum logic [1:0] {CDE_KEY_128 = 2'h0, CDE_KEY_192 = 2'h1, CDE_KEY_256 = 2'h2} cde_key_t;
  typedef enum logic [1:0] {CDE_HASH_NONE = 2'h0, CDE_HASH_MD5 = 2'h1, CDE_HASH_SHA1 = 2'h2,
                            CDE_HASH_SHA256 = 2'h3} cde_hash_t;

  typedef struct packed {
    logic [17:0] rsvd;
    logic last_seg;
    logic parallel;
    logic hmac;
    cde_hash_t hash;
    logic gcm;
    cde_mode_t mode;
    cde_key_t key;
    cde_cipher_t cipher;
  } cde_sa_t;

  // ===================================================================
  // Carriers for the memory master and the engine data ports.
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cde_mem_req_t;

  typedef struct packed {
    logic last;
    logic [31:0] data;
  } cde_word_t;

  typedef struct packed {
    logic desc_done;
    logic pkt_done;
    logic bus_err;
    logic cfg_err;
  } cde_status_t;

  // ===================================================================
  // Control states, one-hot.
  typedef enum logic [9:0] {
    CDE_S_IDLE = 10'h001, CDE_S_FETCH = 10'h002, CDE_S_CHECK = 10'h004, CDE_S_READ = 10'h008,
    CDE_S_PROC = 10'h010, CDE_S_WRITE = 10'h020, CDE_S_DIGEST = 10'h040, CDE_S_WBACK = 10'h080,
    CDE_S_NEXT = 10'h100, CDE_S_ERR = 10'h200
  } cde_state_t;

endpackage

/* File: tb/cde_mem_model.sv */
// Word memory on the engine's master port, with wait states and a fault.
// Assumes the engine holds req, we, addr and wdata until ack or err.
`timescale 1ns/1ps
module cde_mem_model (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Master port of the engine.
  input wire cde_pkg::cde_mem_req_t mem_in,
  output logic ack_out,
  output logic err_out,
  output logic [31:0] rdata_out,
  // Test controls.
  input wire logic slow_in,
  input wire logic [31:0] err_addr_in
);
  logic [31:0] words [0:255];
  logic [1:0] wait_q;
  // ==========================================================
  // One answer per access after zero or three waits.
  // Read data is inverted outside the answer cycle, so a stale word never passes.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_out <= 1'b0;
      err_out <= 1'b0;
      wait_q <= 2'h0;
      rdata_out <= 32'h0;
    end else if (ack_out || err_out || !mem_in.req || wait_q != 2'h0) begin
      ack_out <= 1'b0;
      err_out <= 1'b0;
      wait_q <= (mem_in.req && !ack_out && !err_out) ? wait_q - 2'h1 : {2{slow_in}};
      rdata_out <= ~rdata_out;
    end else begin
      err_out <= mem_in.addr == err_addr_in;
      ack_out <= mem_in.addr != err_addr_in;
      rdata_out <= words[mem_in.addr[9:2]];
      if (mem_in.we && mem_in.addr != err_addr_in) words[mem_in.addr[9:2]] <= mem_in.wdata;
    end
  end
endmodule // cde_mem_model

/* File: tb/crypto_descriptor_dma_engine_tb_top.sv */
// Self-checking bench for the crypto descriptor DMA engine.
// Assumes cde_pkg and the memory model; the cores are simple stand-ins here.
`timescale 1ns/1ps
module crypto_descriptor_dma_engine_tb_top;
  // ==========================================================
  // Signals.
  localparam logic [31:0] KEY = 32'h5a5a_0f0f;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic start_in = 1'b0;
  logic clear_in = 1'b0;
  logic slow = 1'b0;
  logic cph_ready_in = 1'b1;
  logic hsh_ready_in = 1'b1;
  logic cph_rvalid_in = 1'b0;
  logic dig_valid_in = 1'b0;
  logic [31:0] first_desc_in = 32'h0;
  logic [31:0] err_addr = 32'hffff_fffc;
  logic [31:0] cph_rdata_in = 32'h0;
  logic [31:0] dig_data_in = 32'h0;
  logic busy_out, sa_load_out, cph_valid_out, hsh_valid_out, dig_ready_out, mem_ack_in, mem_err_in;
  logic [31:0] mem_rdata_in;
  cde_pkg::cde_status_t stat_out;
  cde_pkg::cde_mem_req_t mem_out;
  cde_pkg::cde_sa_t sa_out;
  cde_pkg::cde_word_t cph_word_out, hsh_word_out;
  logic [31:0] hw [0:15];
  int hn, loads, lasts;
  int failures = 0;
  int total_checks = 0;

  cde_engine dut (.ref_clk_in, .reset_in, .start_in, .first_desc_in, .clear_in, .busy_out, .stat_out,
    .mem_out, .mem_ack_in, .mem_err_in, .mem_rdata_in, .sa_out, .sa_load_out, .cph_valid_out,
    .cph_word_out, .cph_ready_in, .cph_rvalid_in, .cph_rdata_in, .hsh_valid_out, .hsh_word_out,
    .hsh_ready_in, .dig_ready_out, .dig_valid_in, .dig_data_in);
  cde_mem_model mem (.ref_clk_in, .reset_in, .mem_in(mem_out), .ack_out(mem_ack_in), .err_out(mem_err_in),
    .rdata_out(mem_rdata_in), .slow_in(slow), .err_addr_in(err_addr));

  always #2.5 ref_clk_in = ~ref_clk_in;

  // ==========================================================
  // Core stand-ins: cipher XORs a key, digest words count up from a base.
  // Slow mode toggles the readies so held valids get exercised.
  always @(posedge ref_clk_in) begin
    cph_ready_in <= slow ? ~cph_ready_in : 1'b1;
    hsh_ready_in <= slow ? ~hsh_ready_in : 1'b1;
    cph_rvalid_in <= cph_valid_out && cph_ready_in;
    cph_rdata_in <= (cph_valid_out && cph_ready_in) ? cph_word_out.data ^ KEY : ~cph_rdata_in;
    dig_valid_in <= dig_ready_out;
    if (dig_valid_in && dig_ready_out) dig_data_in <= dig_data_in + 32'h1;
    if (hsh_valid_out && hsh_ready_in) hw[hn[3:0]] <= hsh_word_out.data;
    hn <= hn + int'(hsh_valid_out && hsh_ready_in);
    loads <= loads + int'(sa_load_out);
    lasts <= lasts + int'(cph_valid_out && cph_ready_in && cph_word_out.last);
  end

  // ==========================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Flags f are {last_seg, parallel, hmac, gcm}.
  function automatic logic [31:0] mk(input logic [2:0] c, input logic [1:0] k, input logic [2:0] m,
                                     input logic [1:0] h, input logic [3:0] f);
    return {18'h0, f[3], f[2], f[1], h, f[0], m, k, c};
  endfunction

  task automatic put_desc(input logic [31:0] a, sa, nxt, src, len, off);
    logic [31:0] d [0:6];
    d = '{sa, src, src + 32'h100, nxt, 32'h300, len, off};
    for (int i = 0; i < 7; i++) mem.words[a[9:2] + i] = d[i];
    // Nine words, so the word after an eight-word digest reads back as zero.
    for (int i = 0; i < 9; i++) begin
      mem.words[src[9:2] + i] = {src[15:0], 16'(i)} ^ 32'h3c00_00c3;
      mem.words[src[9:2] + 64 + i] = 32'h0;
      mem.words[192 + i] = 32'h0;
    end
  endtask

  task automatic go(input logic [31:0] a);
    int n;
    n = 0;
    // Counters are zeroed off the edge, so the sampling process cannot write back stale counts.
    #1;
    hn = 0;
    loads = 0;
    lasts = 0;
    @(posedge ref_clk_in);
    clear_in <= 1'b1;
    first_desc_in <= a;
    dig_data_in <= 32'hd000_0000;
    @(posedge ref_clk_in);
    clear_in <= 1'b0;
    start_in <= 1'b1;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (busy_out !== 1'b0 && n < 3000);
    if (n == 3000) begin
      failures++;
      $display("FAIL at %0t: engine stuck busy", $time);
      report_and_stop();
    end
  endtask

  task automatic check_data(input logic [31:0] src, tot, off, input int nd, input logic ciph);
    logic [31:0] s;
    for (int i = 0; i < (tot + 3) / 4; i++) begin
      s = mem.words[src[9:2] + i];
      chk(mem.words[src[9:2] + 64 + i], (ciph && i >= off / 4) ? s ^ KEY : s);
    end
    chk(mem.words[src[9:2] + 64 + (tot + 3) / 4], 32'h0);
    for (int k = 0; k < nd; k++) chk(mem.words[192 + k], 32'hd000_0000 + k);
    chk(mem.words[192 + nd], 32'h0);
  endtask

  task automatic one(input logic [31:0] sa, len, off, input int nd, input logic [3:0] st);
    put_desc(32'h0, sa, 32'h0, 32'h100, len, off);
    go(32'h0);
    if (st[3]) check_data(32'h100, sa[8] ? len + off : len, off, nd, sa[2:0] != 3'h0);
    chk({28'h0, stat_out}, {28'h0, st});
    chk(loads, {31'h0, st[3]});
  endtask

  // ==========================================================
  // Scenarios.
  task automatic s_serial();
    one(mk(3'h1, 2'h0, 3'h1, 2'h2, 4'h8), 32'h8, 32'h0, 5, 4'hc);
    for (int i = 0; i < 2; i++) chk(hw[i], mem.words[128 + i]);
    chk(sa_out, mk(3'h1, 2'h0, 3'h1, 2'h2, 4'h8));
    chk(lasts, 32'h1);
  endtask

  task automatic s_parallel();
    @(posedge ref_clk_in);
    slow <= 1'b1;
    one(mk(3'h1, 2'h2, 3'h2, 2'h3, 4'hc), 32'h8, 32'h0, 8, 4'hc);
    for (int i = 0; i < 2; i++) chk(hw[i], mem.words[64 + i]);
    @(posedge ref_clk_in);
    slow <= 1'b0;
  endtask

  task automatic s_modes();
    for (int m = 0; m < 5; m++) begin
      one(mk(3'h1, 2'(m % 3), 3'(m), 2'h0, 4'h8), 32'h4, 32'h0, 0, 4'hc);
      one(mk(3'h2 + 3'(m % 2), 2'h0, 3'(m), 2'h0, 4'h8), 32'h4, 32'h0, 0, (m == 2) ? 4'h1 : 4'hc);
    end
  endtask

  task automatic s_auth();
    int nd [0:3] = '{0, 4, 5, 8};
    for (int h = 1; h < 4; h++) one(mk(3'h0, 2'h0, 3'h0, 2'(h), 4'ha), 32'h8, 32'h0, nd[h], 4'hc);
    one(mk(3'h1, 2'h0, 3'h2, 2'h0, 4'h9), 32'h8, 32'h4, 4, 4'hc);
  endtask

  task automatic s_chain();
    put_desc(32'h0, mk(3'h1, 2'h1, 3'h0, 2'h2, 4'h0), 32'h40, 32'h100, 32'h4, 32'h0);
    put_desc(32'h40, mk(3'h1, 2'h1, 3'h0, 2'h2, 4'h8), 32'h0, 32'h120, 32'h8, 32'h0);
    go(32'h0);
    // second segment via next pointer.
    // Both segments share one write-back area, so the final digest shows here as well.
    check_data(32'h100, 32'h4, 32'h0, 5, 1'b1);
    check_data(32'h120, 32'h8, 32'h0, 5, 1'b1);
    chk(loads, 32'h2);
    chk(lasts, 32'h1);
    chk({28'h0, stat_out}, 32'hc);
  endtask

  task automatic s_buserr();
    @(posedge ref_clk_in);
    err_addr <= 32'h104;
    put_desc(32'h0, mk(3'h1, 2'h0, 3'h0, 2'h0, 4'h8), 32'h0, 32'h100, 32'h8, 32'h0);
    go(32'h0);
    chk({28'h0, stat_out}, 32'h2);
    @(posedge ref_clk_in);
    clear_in <= 1'b1;
    err_addr <= 32'hffff_fffc;
    @(posedge ref_clk_in);
    clear_in <= 1'b0;
    #1;
    chk({28'h0, stat_out}, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    s_serial();
    s_parallel();
    s_modes();
    s_auth();
    s_chain();
    s_buserr();
    report_and_stop();
  end
endmodule // crypto_descriptor_dma_engine_tb_top
